/* rtl/pwm_decoder_pkg.sv */
// Shared constants, register map and carrier types for the PWM input decoder
package pwm_decoder_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int DEAD_TIME_NS  = 100;
  localparam int DEAD_CYCLES   = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES   = 2;
  localparam int PHASES        = 3;

  // Register map (byte addresses)
  localparam int        ADDR_W      = 4;
  localparam logic [3:0] CTRL_OFFS   = 4'h0;
  localparam logic [3:0] STATUS_OFFS = 4'h4;
  localparam logic [3:0] GATES_OFFS  = 4'h8;

  // Control field layout
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_ASYNC_BIT = 3;
  localparam int CTRL_EN_LSB    = 4;
  localparam int CTRL_W         = 7;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  // Status field layout
  localparam int STATUS_FAULT_LSB = 0;
  localparam logic [2:0] FAULT_RESET = 3'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Gate-control modes
  typedef enum logic [2:0] {
    MODE_SIX       = 3'h0,
    MODE_THREE_PIN = 3'h1,
    MODE_THREE_REG = 3'h2,
    MODE_SINGLE    = 3'h3
  } pwm_mode_t;

  // Commutation state codes, direction low
  localparam logic [2:0] STEP_STOP   = 3'h0;
  localparam logic [2:0] STEP_ALIGN  = 3'h7;
  localparam logic [2:0] STEP_B_TO_C = 3'h6;
  localparam logic [2:0] STEP_A_TO_C = 3'h4;
  localparam logic [2:0] STEP_A_TO_B = 3'h5;
  localparam logic [2:0] STEP_C_TO_B = 3'h1;
  localparam logic [2:0] STEP_C_TO_A = 3'h3;
  localparam logic [2:0] STEP_B_TO_A = 3'h2;

  // Phase indices
  localparam logic [1:0] PH_A = 2'h0;
  localparam logic [1:0] PH_B = 2'h1;
  localparam logic [1:0] PH_C = 2'h2;

  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } gate_cmd_t;

  typedef struct packed {
    logic [2:0] drive_enable;
    logic       async_sel;
    logic [2:0] mode;
  } ctrl_t;

endpackage

/* rtl/input_sync.sv */
// Two-stage synchroniser for a bundle of input pins
`timescale 1ns/1ps
module input_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] pins,
  output logic      [WIDTH-1:0] pins_sync
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg  <= '0;
      pins_sync <= '0;
    end
    else
    begin
      meta_reg  <= pins;
      pins_sync <= meta_reg;
    end
  end

endmodule

/* rtl/gate_dead_time.sv */
// One half-bridge gate pair with optional dead-time insertion
`timescale 1ns/1ps
module gate_dead_time #(
  parameter int DEAD = 5
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic insert_dead,
  input  wire logic hi_req,
  input  wire logic lo_req,
  output logic      hi_out,
  output logic      lo_out
);

  logic [7:0] cnt_reg;
  logic       ready_on;

  assign ready_on = (cnt_reg == 8'h00);

  // With insertion on, a gate turns on only after the opposite gate is off and the gap has elapsed
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hi_out <= 1'b0;
      lo_out <= 1'b0;
    end
    else if (!insert_dead)
    begin
      hi_out <= hi_req;
      lo_out <= lo_req;
    end
    else
    begin
      hi_out <= hi_req & !lo_req & (hi_out | (!lo_out & ready_on));
      lo_out <= lo_req & !hi_req & (lo_out | (!hi_out & ready_on));
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !insert_dead)
      cnt_reg <= 8'h00;
    else if ((hi_out & !(hi_req & !lo_req)) | (lo_out & !(lo_req & !hi_req)))
      cnt_reg <= 8'(DEAD);
    else if (!ready_on)
      cnt_reg <= cnt_reg - 8'h01;
  end

endmodule

/* rtl/three_phase_pwm_input_decoder.sv */
// Three-phase PWM input decoder with AXI4-Lite control and status registers
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module three_phase_pwm_input_decoder #(
  parameter int DEAD_CYCLES = pwm_decoder_pkg::DEAD_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [3:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [3:0]  araddr,
  input  wire logic [2:0]  arprot,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic [2:0]  high_side_input,
  input  wire logic [2:0]  low_side_input,
  output logic [2:0]       high_gate_out,
  output logic [2:0]       low_gate_out,
  output logic             shoot_through_fault
);

  localparam int DEAD_BOUND = DEAD_CYCLES + 3;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  pwm_decoder_pkg::ctrl_t     ctrl_reg;
  logic [2:0]                 fault_reg;
  logic [2:0]                 hs_s;
  logic [2:0]                 ls_s;
  pwm_decoder_pkg::gate_cmd_t req;
  pwm_decoder_pkg::gate_cmd_t single_req;
  pwm_decoder_pkg::gate_cmd_t gates;
  logic                       six_mode;
  logic                       single_mode;
  logic [2:0]                 st_hit;

  // Commutation signals
  logic       pwm;
  logic       dir;
  logic       brake_n;
  logic [2:0] code_raw;
  logic [2:0] code_eff;
  logic [1:0] src;
  logic [1:0] snk;
  logic       step_active;

  // Bus state
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        do_write;
  logic        fault_clr_hit;
  logic [2:0]  fault_clr;

  // Pins pass through two flops first; gate edges then land on clock edges only
  input_sync #(
    .WIDTH (6)
  ) u_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pins      ({low_side_input, high_side_input}),
    .pins_sync ({ls_s, hs_s})
  );

  assign six_mode    = (ctrl_reg.mode == pwm_decoder_pkg::MODE_SIX);
  assign single_mode = (ctrl_reg.mode == pwm_decoder_pkg::MODE_SINGLE);

  // Single-PWM pin roles
  assign pwm      = hs_s[0];
  assign code_raw = {ls_s[0], hs_s[1], ls_s[1]};
  assign dir      = hs_s[2];
  assign brake_n  = ls_s[2];

  // Reverse direction inverts every code except stop and align
  always_comb
  begin
    if (dir && code_raw != pwm_decoder_pkg::STEP_STOP &&
        code_raw != pwm_decoder_pkg::STEP_ALIGN)
      code_eff = ~code_raw;
    else
      code_eff = code_raw;
  end

  always_comb
  begin
    src         = pwm_decoder_pkg::PH_A;
    snk         = pwm_decoder_pkg::PH_A;
    step_active = 1'b1;
    case (code_eff)
      pwm_decoder_pkg::STEP_B_TO_C: {src, snk} = {pwm_decoder_pkg::PH_B, pwm_decoder_pkg::PH_C};
      pwm_decoder_pkg::STEP_A_TO_C: {src, snk} = {pwm_decoder_pkg::PH_A, pwm_decoder_pkg::PH_C};
      pwm_decoder_pkg::STEP_A_TO_B: {src, snk} = {pwm_decoder_pkg::PH_A, pwm_decoder_pkg::PH_B};
      pwm_decoder_pkg::STEP_C_TO_B: {src, snk} = {pwm_decoder_pkg::PH_C, pwm_decoder_pkg::PH_B};
      pwm_decoder_pkg::STEP_C_TO_A: {src, snk} = {pwm_decoder_pkg::PH_C, pwm_decoder_pkg::PH_A};
      pwm_decoder_pkg::STEP_B_TO_A: {src, snk} = {pwm_decoder_pkg::PH_B, pwm_decoder_pkg::PH_A};
      default:
        step_active = 1'b0;
    endcase
  end

  always_comb
  begin
    single_req = '0;
    if (!brake_n)
    begin
      single_req.low = 3'h7;
    end
    else if (code_eff == pwm_decoder_pkg::STEP_ALIGN)
    begin
      single_req.high[0] = pwm;
      single_req.low[0]  = !ctrl_reg.async_sel && !pwm;
      single_req.low[1]  = 1'b1;
      single_req.low[2]  = 1'b1;
    end
    else if (step_active)
    begin
      single_req.high[src] = pwm;
      single_req.low[src]  = !ctrl_reg.async_sel && !pwm;
      single_req.low[snk]  = 1'b1;
    end
  end

  assign st_hit = hs_s & ls_s;

  // Mode decode, then the drive-enable mask over every mode
  always_comb
  begin
    req = '0;
    case (ctrl_reg.mode)
      pwm_decoder_pkg::MODE_SIX:
      begin
        req.high = hs_s & ~st_hit;
        req.low  = ls_s & ~st_hit;
      end
      pwm_decoder_pkg::MODE_THREE_PIN:
      begin
        req.high = hs_s & ls_s;
        req.low  = ~hs_s & ls_s;
      end
      pwm_decoder_pkg::MODE_THREE_REG:
      begin
        req.high = hs_s;
        req.low  = ~hs_s;
      end
      pwm_decoder_pkg::MODE_SINGLE:
        req = single_req;
      default:
        req = '0;
    endcase
    req.high = req.high & ctrl_reg.drive_enable;
    req.low  = req.low & ctrl_reg.drive_enable;
  end

  // Outside six-input mode opposite gates never switch without a gap
  genvar g;
  generate
    for (g = 0; g < pwm_decoder_pkg::PHASES; g++)
    begin : g_phase
      gate_dead_time #(
        .DEAD (DEAD_CYCLES)
      ) u_dead (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .insert_dead (!six_mode),
        .hi_req      (req.high[g]),
        .lo_req      (req.low[g]),
        .hi_out      (gates.high[g]),
        .lo_out      (gates.low[g])
      );
    end
  endgenerate

  assign high_gate_out       = gates.high;
  assign low_gate_out        = gates.low;
  assign shoot_through_fault = |fault_reg;

  // Write channel: address and data taken in either order
  assign awready  = !aw_held && !bvalid;
  assign wready   = !w_held && !bvalid;
  assign do_write = aw_held && w_held && !bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held     <= 1'b0;
      aw_addr_reg <= 4'h0;
    end
    else if (awvalid && awready)
    begin
      aw_held     <= 1'b1;
      aw_addr_reg <= awaddr;
    end
    else if (do_write)
      aw_held <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held     <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      w_held     <= 1'b1;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end
    else if (do_write)
      w_held <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= pwm_decoder_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      if (aw_addr_reg == pwm_decoder_pkg::CTRL_OFFS ||
          aw_addr_reg == pwm_decoder_pkg::STATUS_OFFS ||
          aw_addr_reg == pwm_decoder_pkg::GATES_OFFS)
        bresp <= pwm_decoder_pkg::RESP_OKAY;
      else
        bresp <= pwm_decoder_pkg::RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_reg <= pwm_decoder_pkg::ctrl_t'(pwm_decoder_pkg::CTRL_RESET);
    else if (do_write && w_strb_reg[0] && aw_addr_reg == pwm_decoder_pkg::CTRL_OFFS)
      ctrl_reg <= pwm_decoder_pkg::ctrl_t'(w_data_reg[pwm_decoder_pkg::CTRL_W-1:0]);
  end

  // Write one to clear; a fresh fault in the same cycle stays set
  assign fault_clr_hit = do_write && w_strb_reg[0] &&
                         aw_addr_reg == pwm_decoder_pkg::STATUS_OFFS;
  assign fault_clr     = fault_clr_hit ? w_data_reg[2:0] : 3'h0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fault_reg <= pwm_decoder_pkg::FAULT_RESET;
    else
      fault_reg <= (fault_reg & ~fault_clr) | (six_mode ? st_hit : 3'h0);
  end

  // Read channel
  assign arready = !rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= pwm_decoder_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rresp  <= pwm_decoder_pkg::RESP_OKAY;
      case (araddr)
        pwm_decoder_pkg::CTRL_OFFS:
          rdata <= {25'h0, ctrl_reg};
        pwm_decoder_pkg::STATUS_OFFS:
          rdata <= {29'h0, fault_reg};
        pwm_decoder_pkg::GATES_OFFS:
          rdata <= {26'h0, gates};
        default:
        begin
          rdata <= 32'h0000_0000;
          rresp <= pwm_decoder_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // Checks
  a_six_shoot_block: assert property (
    (six_mode && |st_hit) |=> (((gates.high | gates.low) & $past(st_hit)) == 3'h0))
    else $error("six-input overlap not blocked");
  a_six_fault_set: assert property (
    (six_mode && |st_hit) |=> shoot_through_fault ##1 shoot_through_fault)
    else $error("shoot-through fault flag not set or not sticky");
  a_drive_mask_off: assert property (
    (ctrl_reg.drive_enable == 3'h0) |=> (gates.high == 3'h0 && gates.low == 3'h0))
    else $error("gates active with drive enables cleared");
  a_pin_enable_off: assert property (
    (ctrl_reg.mode == pwm_decoder_pkg::MODE_THREE_PIN && !ls_s[1])
      |=> (!gates.high[1] && !gates.low[1]))
    else $error("pin enable low did not turn phase B off");
  a_no_gate_overlap: assert property (
    !(|(gates.high & gates.low)))
    else $error("both gates of one phase on together");
  a_brake_highs_off: assert property (
    (single_mode && !brake_n) |=> (gates.high == 3'h0))
    else $error("brake did not turn high-side gates off");
  a_brake_lows_on: assert property (
    (single_mode && !brake_n && ctrl_reg.drive_enable == 3'h7)
      |-> ##[1:DEAD_BOUND] (gates.low == 3'h7))
    else $error("brake did not turn low-side gates on in time");
  a_reg_en_ignore: assert property (
    (ctrl_reg.mode == pwm_decoder_pkg::MODE_THREE_REG && ctrl_reg.drive_enable[2] &&
     !hs_s[2] && gates.low[2] && $stable(ctrl_reg)) |=> gates.low[2])
    else $error("register-enable mode reacted to low-side input");
  a_async_low_off: assert property (
    (single_mode && ctrl_reg.async_sel && brake_n &&
     code_eff == pwm_decoder_pkg::STEP_A_TO_C) |=> !gates.low[0])
    else $error("async mode drove source low-side gate");
  a_step_sink_low: assert property (
    (single_mode && brake_n && code_eff == pwm_decoder_pkg::STEP_A_TO_B &&
     ctrl_reg.drive_enable == 3'h7)[*8] |=> (gates.low[1] && !gates.high[2] && !gates.low[2]))
    else $error("commutation step A to B drives wrong gates");

endmodule

/* dv/motor_ctrl_model.sv */
// Behavioural model of the motor controller that drives the decoder input pins
`timescale 1ns/1ps
module motor_ctrl_model (
  input  wire logic       aclk,
  input  wire logic       single,
  input  wire logic [2:0] six_hi,
  input  wire logic [2:0] six_lo,
  input  wire logic       pwm,
  input  wire logic [2:0] hall,
  input  wire logic       dir,
  input  wire logic       brake_n,
  output logic      [2:0] high_side_input,
  output logic      [2:0] low_side_input
);
  // Pins move just after the edge, as from a clocked controller
  always_ff @(posedge aclk)
  begin
    if (single)
    begin
      high_side_input <= {dir, hall[1], pwm};
      low_side_input  <= {brake_n, hall[0], hall[2]};
    end
    else
    begin
      high_side_input <= six_hi;
      low_side_input  <= six_lo;
    end
  end
endmodule

/* dv/tb_three_phase_pwm_input_decoder.sv */
// Self-checking bench for the three-phase PWM input decoder
`timescale 1ns/1ps
module tb_three_phase_pwm_input_decoder;
  localparam int DEAD = 2;
  localparam int SRC_OF [8] = '{3, 2, 1, 2, 0, 0, 1, 0};
  localparam int SNK_OF [8] = '{3, 1, 0, 0, 2, 1, 2, 1};
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, shoot_through_fault;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [2:0]  awprot, arprot, high_side_input, low_side_input;
  logic [2:0]  high_gate_out, low_gate_out, six_hi, six_lo, hall;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rsp;
  logic        single, pwm, dir, brake_n;
  int          num_errors, samples_checked, cycles, gap;
  pwm_decoder_pkg::gate_cmd_t g;

  three_phase_pwm_input_decoder #(.DEAD_CYCLES(DEAD)) DUT (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot, .rvalid,
    .rready, .rdata, .rresp, .high_side_input, .low_side_input, .high_gate_out,
    .low_gate_out, .shoot_through_fault
  );
  motor_ctrl_model ctrl_model (
    .aclk, .single, .six_hi, .six_lo, .pwm, .hall, .dir, .brake_n,
    .high_side_input, .low_side_input
  );

  always #10 aclk = ~aclk;

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Generous ceiling; the full sequence needs about 1200 cycles
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      end_of_test;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Ready is sampled on the falling edge, where it stands settled before the next rise
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, da, dw, b;
    da = 0;
    dw = 0;
    b = 0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hf;
    bready  <= 1'b1;
    while (!(da && dw))
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge aclk);
      da = da || ta;
      dw = dw || tw;
      awvalid <= awvalid && !ta;
      wvalid  <= wvalid && !tw;
    end
    while (!b)
    begin
      @(negedge aclk);
      b = bvalid;
      r = bresp;
      @(posedge aclk);
    end
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t, v;
    t = 0;
    v = 0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    while (!t)
    begin
      @(negedge aclk);
      t = arready;
      @(posedge aclk);
    end
    arvalid <= 1'b0;
    while (!v)
    begin
      @(negedge aclk);
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
    end
    rready <= 1'b0;
  endtask

  task automatic ctrl(input logic [2:0] m, input logic a, input logic [2:0] e);
    axi_write(pwm_decoder_pkg::CTRL_OFFS, {25'h0, e, a, m}, rsp);
    check({30'h0, rsp}, {30'h0, pwm_decoder_pkg::RESP_OKAY});
  endtask

  task automatic pins(input logic [2:0] h, input logic [2:0] l);
    @(posedge aclk);
    six_hi <= h;
    six_lo <= l;
  endtask

  // Long enough for sync, output register and two dead gaps
  task automatic settle;
    repeat (12) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic gates(input logic [2:0] h, input logic [2:0] l);
    settle;
    check({26'h0, high_gate_out, low_gate_out}, {26'h0, h, l});
  endtask

  function automatic pwm_decoder_pkg::gate_cmd_t exp_single(input logic [2:0] c,
                                                           input logic p, input logic as);
    pwm_decoder_pkg::gate_cmd_t e;
    e = '0;
    if (SRC_OF[c] < 3)
    begin
      e.high[SRC_OF[c]] = p;
      e.low[SNK_OF[c]]  = 1'b1;
      e.low[SRC_OF[c]]  = !p && !as;
      e.low[2]          = e.low[2] || (c == 3'h7);
    end
    return e;
  endfunction

  initial
  begin
    aclk = 0;
    aresetn = 0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wstrb, wdata, awprot, arprot} = '0;
    {single, pwm, dir, six_hi, six_lo, hall} = '0;
    brake_n = 1;
    num_errors = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(pwm_decoder_pkg::CTRL_OFFS, rd, rsp);
    check(rd, 32'h0);
    axi_read(pwm_decoder_pkg::STATUS_OFFS, rd, rsp);
    check(rd, 32'h0);
    axi_read(4'hc, rd, rsp);
    check(rd, 32'h0);
    check({30'h0, rsp}, {30'h0, pwm_decoder_pkg::RESP_SLVERR});
    axi_write(4'hc, 32'h7f, rsp);
    check({30'h0, rsp}, {30'h0, pwm_decoder_pkg::RESP_SLVERR});
    pins(3'h1, 3'h2);
    gates(3'h0, 3'h0);
    ctrl(pwm_decoder_pkg::MODE_SIX, 1'b0, 3'h7);
    gates(3'h1, 3'h2);
    axi_read(pwm_decoder_pkg::GATES_OFFS, rd, rsp);
    check(rd, 32'h0a);
    axi_read(pwm_decoder_pkg::CTRL_OFFS, rd, rsp);
    check(rd, 32'h70);
    pins(3'h5, 3'h4);
    gates(3'h1, 3'h0);
    check({31'h0, shoot_through_fault}, 32'h1);
    axi_read(pwm_decoder_pkg::STATUS_OFFS, rd, rsp);
    check(rd, 32'h4);
    pins(3'h1, 3'h2);
    gates(3'h1, 3'h2);
    check({31'h0, shoot_through_fault}, 32'h1);
    axi_write(pwm_decoder_pkg::STATUS_OFFS, 32'h4, rsp);
    axi_read(pwm_decoder_pkg::STATUS_OFFS, rd, rsp);
    check(rd, 32'h0);
    check({31'h0, shoot_through_fault}, 32'h0);
    pins(3'h0, 3'h0);
    settle;
    pins(3'h1, 3'h0);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    check({29'h0, high_gate_out}, 32'h0);
    gates(3'h1, 3'h0);
    ctrl(pwm_decoder_pkg::MODE_THREE_PIN, 1'b0, 3'h7);
    pins(3'h5, 3'h3);
    gates(3'h1, 3'h2);
    ctrl(pwm_decoder_pkg::MODE_THREE_REG, 1'b0, 3'h7);
    pins(3'h5, 3'h0);
    gates(3'h5, 3'h2);
    ctrl(pwm_decoder_pkg::MODE_THREE_REG, 1'b0, 3'h3);
    gates(3'h1, 3'h2);
    ctrl(pwm_decoder_pkg::MODE_THREE_REG, 1'b0, 3'h7);
    pins(3'h0, 3'h4);
    gates(3'h0, 3'h7);
    pins(3'h0, 3'h0);
    gates(3'h0, 3'h7);
    pins(3'h4, 3'h0);
    settle;
    pins(3'h5, 3'h0);
    gap = 0;
    repeat (16)
    begin
      @(negedge aclk);
      gap += int'(high_gate_out[0] === 1'b0 && low_gate_out[0] === 1'b0);
    end
    check({31'h0, gap >= DEAD}, 32'h1);
    check({31'h0, high_gate_out[0]}, 32'h1);
    ctrl(3'h4, 1'b0, 3'h7);
    gates(3'h0, 3'h0);
    @(posedge aclk);
    single <= 1'b1;
    for (int a = 0; a < 2; a++)
    begin
      ctrl(pwm_decoder_pkg::MODE_SINGLE, a[0], 3'h7);
      for (int d = 0; d < 2; d++)
        for (int c = 0; c < 8; c++)
          for (int p = 0; p < 2; p++)
          begin
            @(posedge aclk);
            dir  <= d[0];
            hall <= (d == 1 && c != 0 && c != 7) ? ~c[2:0] : c[2:0];
            pwm  <= p[0];
            settle;
            g = exp_single(c[2:0], p[0], a[0]);
            check({26'h0, high_gate_out, low_gate_out}, {26'h0, g});
          end
    end
    @(posedge aclk);
    brake_n <= 1'b0;
    gates(3'h0, 3'h7);
    @(posedge aclk);
    hall <= 3'h4;
    dir  <= 1'b0;
    pwm  <= 1'b0;
    gates(3'h0, 3'h7);
    end_of_test;
  end
endmodule
